// file: verilog/mo_ctrl_pkg.sv
// constants, types and field layout of the message object control block
// Operation
// - pairs: write 01 clears, 10 sets, 11 keeps; read 01 cleared, 10 set
// - written type, node, direction take effect only when valid is written 10
// - transmit object: new data cleared when its frame transmission starts
// - receive object: matching data frame stored sets new data; software clears
// - bytes beyond received length may hold unspecified values
// - valid object, matching remote frame sets transmit request and remote pending
// - no frame sent unless cpu update element is cleared
// - request on receive object sends remote frame, on transmit object data frame
// - remote sent clears both; data sent clears both unless new data set again
// - remote monitoring on transmit object copies remote identifier and length
// - node select bit 1: 0 node a, 1 node b
// - identifier type bit: 0 standard 11-bit, 1 extended 29-bit
// - receive object stores payload of matching data frame in data registers
// - length field bits 7:4; values above 8 used as 8, field keeps value
// - received length above 8 stores 8 bytes, field keeps original code
// - hardware may overwrite length field in remote monitoring mode
// - receive pointer high bits 2:0 picks interrupt node when receive irq enabled
// - transmit pointer high bits 6:4 picks interrupt node when transmit irq enabled
// - unused configuration bits read zero; software writes zero
// - only objects marked valid are processed
// - lowest numbered pending object is transmitted first
package mo_ctrl_pkg;
    localparam int NUM_OBJ = 4;
    localparam int OBJ_W = 2;
    localparam int OBJ_LSB = 5;
    localparam int REG_LSB = 2;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_CFG = 3'h1;
    localparam logic [2:0] REG_ARB = 3'h2;
    localparam logic [2:0] REG_DLO = 3'h3;
    localparam logic [2:0] REG_DHI = 3'h4;
    localparam logic [1:0] EL_CLR = 2'h1;
    localparam logic [1:0] EL_SET = 2'h2;
    // control pair positions, low half
    localparam int P_INTPND = 0;
    localparam int P_RECEIVE_IRQ_ENABLE = 2;
    localparam int P_TRANSMIT_IRQ_ENABLE = 4;
    localparam int P_VALID = 6;
    localparam int P_NEW_DATA_FLAG = 8;
    localparam int P_LOST = 10;
    localparam int P_TRANSMIT_REQUEST = 12;
    localparam int P_REMOTE_PENDING = 14;
    // configuration positions
    localparam int C_RMM = 0;
    localparam int C_NODE = 1;
    localparam int C_XTD = 2;
    localparam int C_DIR = 3;
    localparam int C_DLC = 4;
    localparam int C_RXP = 16;
    localparam int C_TXP = 20;
    localparam logic [3:0] DLC_MAX = 4'h8;
    localparam logic [7:0] IRQ_ONE = 8'h01;

    typedef struct packed {
        logic [OBJ_W-1:0] obj;
        logic node;
        logic remote;
        logic identifier_type;
        logic [28:0] id;
        logic [3:0] dlc;
        logic [63:0] data;
    } frame_t;

    typedef struct packed {
        logic valid;
        logic new_data;
        logic lost_upd;
        logic transmit_request;
        logic remote_pending;
        logic receive_irq_enable;
        logic transmit_irq_enable;
        logic intpnd;
        logic remote_monitoring;
        logic node_w;
        logic xtd_w;
        logic dir_w;
        logic node;
        logic identifier_type;
        logic dir;
        logic [3:0] dlc;
        logic [2:0] rxptr;
        logic [2:0] txptr;
        logic [28:0] id;
        logic [63:0] data;
    } obj_t;

    localparam obj_t OBJ_RST = '0;
endpackage

// file: verilog/mo_ctrl.sv
// message object control, configuration and transmit selection
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module mo_ctrl
    import mo_ctrl_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic rx_valid_in,
    input wire frame_t rx_frame_in,
    input wire logic tx_start_in,
    input wire logic tx_done_in,
    input wire logic tx_fail_in,
    output logic tx_valid_out,
    output frame_t tx_frame_out,
    output logic [7:0] irq_node_out
);

    // --------------------------------------------------------------
    // element pair handling
    // --------------------------------------------------------------
    function automatic logic pair_upd(input logic old, input logic [1:0] p);
        logic r;
        r = old;
        if (p == EL_CLR) begin
            r = 1'b0;
        end else if (p == EL_SET) begin
            r = 1'b1;
        end
        return r;
    endfunction

    function automatic logic [1:0] pair_rd(input logic v);
        return v ? EL_SET : EL_CLR;
    endfunction

    // --------------------------------------------------------------
    // shared decode
    // --------------------------------------------------------------
    wire [OBJ_W-1:0] a_obj = addr_in[OBJ_LSB +: OBJ_W];
    wire [2:0] a_reg = addr_in[REG_LSB +: 3];
    wire a_hi_zero = (addr_in[7] == 1'b0) && (addr_in[1:0] == 2'h0);

    logic busy_q;
    logic [OBJ_W-1:0] tx_sel_q;
    logic tx_valid_q;
    frame_t tx_frame_q;
    logic [31:0] rdata_q;
    logic [7:0] irq_q;

    obj_t objv [NUM_OBJ];
    logic [31:0] rd_word [NUM_OBJ];
    logic [7:0] irq_vec [NUM_OBJ];
    logic [NUM_OBJ-1:0] cand;

    // --------------------------------------------------------------
    // per object state
    // --------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OBJ; gi++) begin : g_obj
            obj_t o_q;
            obj_t o_d;
            wire sel = a_hi_zero && (a_obj == OBJ_W'(gi));
            wire wr_ctrl = wr_in && sel && (a_reg == REG_CTRL);
            wire wr_cfg = wr_in && sel && (a_reg == REG_CFG);
            wire wr_arb = wr_in && sel && (a_reg == REG_ARB);
            wire wr_dlo = wr_in && sel && (a_reg == REG_DLO);
            wire wr_dhi = wr_in && sel && (a_reg == REG_DHI);
            // invalid objects take no part in frame traffic
            wire hit_rx = rx_valid_in && (rx_frame_in.obj == OBJ_W'(gi)) && o_q.valid
                && (o_q.node == rx_frame_in.node) && (o_q.identifier_type == rx_frame_in.identifier_type);
            wire rx_data = hit_rx && !rx_frame_in.remote && !o_q.dir;
            wire rx_rmt = hit_rx && rx_frame_in.remote;
            wire is_sel = busy_q && (tx_sel_q == OBJ_W'(gi));
            wire st_clr = tx_start_in && is_sel && o_q.dir;
            wire dn = tx_done_in && is_sel;
            wire dn_clr = dn && (tx_frame_q.remote || !o_q.new_data);
            wire rx_irq = rx_data && o_q.receive_irq_enable;
            wire tx_irq = dn && o_q.transmit_irq_enable;

            always_comb begin
                o_d = o_q;
                // hardware clears first so that a software set in the same cycle wins
                if (st_clr) begin
                    o_d.new_data = 1'b0;
                end
                if (dn_clr) begin
                    o_d.transmit_request = 1'b0;
                    o_d.remote_pending = 1'b0;
                end
                if (wr_ctrl) begin
                    o_d.intpnd = pair_upd(o_d.intpnd, wdata_in[P_INTPND +: 2]);
                    o_d.receive_irq_enable = pair_upd(o_d.receive_irq_enable, wdata_in[P_RECEIVE_IRQ_ENABLE +: 2]);
                    o_d.transmit_irq_enable = pair_upd(o_d.transmit_irq_enable, wdata_in[P_TRANSMIT_IRQ_ENABLE +: 2]);
                    o_d.valid = pair_upd(o_d.valid, wdata_in[P_VALID +: 2]);
                    o_d.new_data = pair_upd(o_d.new_data, wdata_in[P_NEW_DATA_FLAG +: 2]);
                    o_d.lost_upd = pair_upd(o_d.lost_upd, wdata_in[P_LOST +: 2]);
                    o_d.transmit_request = pair_upd(o_d.transmit_request, wdata_in[P_TRANSMIT_REQUEST +: 2]);
                    o_d.remote_pending = pair_upd(o_d.remote_pending, wdata_in[P_REMOTE_PENDING +: 2]);
                    if (wdata_in[P_VALID +: 2] == EL_SET) begin
                        o_d.node = o_q.node_w;
                        o_d.identifier_type = o_q.xtd_w;
                        o_d.dir = o_q.dir_w;
                    end
                end
                if (wr_cfg) begin
                    o_d.remote_monitoring = wdata_in[C_RMM];
                    o_d.node_w = wdata_in[C_NODE];
                    o_d.xtd_w = wdata_in[C_XTD];
                    o_d.dir_w = wdata_in[C_DIR];
                    o_d.dlc = wdata_in[C_DLC +: 4];
                    o_d.rxptr = wdata_in[C_RXP +: 3];
                    o_d.txptr = wdata_in[C_TXP +: 3];
                end
                if (wr_arb) begin
                    o_d.id = wdata_in[28:0];
                end
                if (wr_dlo) begin
                    o_d.data[31:0] = wdata_in;
                end
                if (wr_dhi) begin
                    o_d.data[63:32] = wdata_in;
                end
                // hardware sets last: they win over a software clear
                if (rx_data) begin
                    // all eight bytes are taken; those past the length are don't-care
                    o_d.data = rx_frame_in.data;
                    o_d.dlc = rx_frame_in.dlc;
                    o_d.lost_upd = o_d.lost_upd | o_q.new_data;
                    o_d.new_data = 1'b1;
                end
                if (rx_rmt) begin
                    o_d.transmit_request = 1'b1;
                    o_d.remote_pending = 1'b1;
                    if (o_q.remote_monitoring && o_q.dir) begin
                        o_d.id = rx_frame_in.id;
                        o_d.dlc = rx_frame_in.dlc;
                    end
                end
                if (rx_irq || tx_irq) begin
                    o_d.intpnd = 1'b1;
                end
            end

            always_ff @(posedge clk_sys_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    o_q <= OBJ_RST;
                end else begin
                    o_q <= o_d;
                end
            end

            assign objv[gi] = o_q;
            assign cand[gi] = o_q.valid && o_q.transmit_request && !o_q.lost_upd;
            assign irq_vec[gi] = (rx_irq ? (IRQ_ONE << o_q.rxptr) : 8'h00)
                | (tx_irq ? (IRQ_ONE << o_q.txptr) : 8'h00);

            // read words; unused configuration bits are zero
            wire [31:0] w_ctrl = {16'h0000, pair_rd(o_q.remote_pending), pair_rd(o_q.transmit_request),
                pair_rd(o_q.lost_upd), pair_rd(o_q.new_data), pair_rd(o_q.valid),
                pair_rd(o_q.transmit_irq_enable), pair_rd(o_q.receive_irq_enable), pair_rd(o_q.intpnd)};
            wire [31:0] w_cfg = {9'h000, o_q.txptr, 1'b0, o_q.rxptr, 8'h00, o_q.dlc,
                o_q.dir_w, o_q.xtd_w, o_q.node_w, o_q.remote_monitoring};
            assign rd_word[gi] = (a_reg == REG_CTRL) ? w_ctrl :
                (a_reg == REG_CFG) ? w_cfg :
                (a_reg == REG_ARB) ? {3'h0, o_q.id} :
                (a_reg == REG_DLO) ? o_q.data[31:0] :
                (a_reg == REG_DHI) ? o_q.data[63:32] : 32'h0000_0000;
        end
    endgenerate

    // --------------------------------------------------------------
    // transmit selection
    // --------------------------------------------------------------
    logic pick_valid;
    logic [OBJ_W-1:0] pick_idx;
    always_comb begin
        pick_valid = 1'b0;
        pick_idx = '0;
        // scan downward so the lowest number is taken last
        for (int k = NUM_OBJ - 1; k >= 0; k--) begin
            if (cand[k]) begin
                pick_valid = 1'b1;
                pick_idx = OBJ_W'(k);
            end
        end
    end

    wire obj_t pick = objv[pick_idx];
    wire [3:0] pick_dlc = (pick.dlc > DLC_MAX) ? DLC_MAX : pick.dlc;
    frame_t tx_next;
    always_comb begin
        tx_next.obj = pick_idx;
        tx_next.node = pick.node;
        tx_next.remote = !pick.dir;
        tx_next.identifier_type = pick.identifier_type;
        tx_next.id = pick.id;
        tx_next.dlc = pick_dlc;
        tx_next.data = pick.data;
    end

    wire tx_end = busy_q && (tx_done_in || tx_fail_in);
    wire tx_take = !busy_q && pick_valid;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            busy_q <= 1'b0;
            tx_sel_q <= '0;
            tx_valid_q <= 1'b0;
            tx_frame_q <= '0;
        end else if (tx_take) begin
            busy_q <= 1'b1;
            tx_sel_q <= pick_idx;
            tx_valid_q <= 1'b1;
            tx_frame_q <= tx_next;
        end else if (tx_end) begin
            busy_q <= 1'b0;
            tx_valid_q <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // interrupt node triggers and register read
    // --------------------------------------------------------------
    logic [7:0] irq_d;
    always_comb begin
        irq_d = 8'h00;
        for (int k = 0; k < NUM_OBJ; k++) begin
            irq_d = irq_d | irq_vec[k];
        end
    end

    wire [31:0] rdata_d = (rd_in && a_hi_zero) ? rd_word[a_obj] : 32'h0000_0000;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_q <= 32'h0000_0000;
            irq_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    assign rdata_out = rdata_q;
    assign tx_valid_out = tx_valid_q;
    assign tx_frame_out = tx_frame_q;
    assign irq_node_out = irq_q;

endmodule // mo_ctrl
`default_nettype wire

// file: tb/mo_ctrl_checker.sv
// port assertions for the message object control block
`timescale 1ns/1ps
`default_nettype none
module mo_ctrl_checker
    import mo_ctrl_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [7:0] addr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic rx_valid_in,
    input wire logic tx_done_in,
    input wire logic tx_fail_in,
    input wire logic tx_valid_out,
    input wire frame_t tx_frame_out,
    input wire logic [7:0] irq_node_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    wire logic ok_a = !addr_in[7] && addr_in[1:0] == 2'h0;
    wire logic rd_ctl = rd_in && ok_a && addr_in[4:2] == REG_CTRL;
    wire logic rd_cfg = rd_in && ok_a && addr_in[4:2] == REG_CFG;
    a_read_idle:
        assert property (!$past(rd_in) |-> rdata_out == 32'h0) else $error("read data not idle");
    a_ctrl_pairs:
        assert property (rd_ctl |=> ^rdata_out[7:6] && ^rdata_out[9:8] && ^rdata_out[13:12]
            && rdata_out[31:16] == 16'h0) else $error("control pair code bad");
    a_cfg_zero:
        assert property (rd_cfg |=> rdata_out[31:23] == 9'h0 && !rdata_out[19]
            && rdata_out[15:8] == 8'h0) else $error("config unused bits set");
    a_unmapped_zero:
        assert property (rd_in && (!ok_a || addr_in[4:2] > REG_DHI) |=> rdata_out == 32'h0)
            else $error("unmapped read not zero");
    a_dlc_clip:
        assert property (tx_valid_out |-> tx_frame_out.dlc <= DLC_MAX) else $error("offered length above 8");
    a_offer_hold:
        assert property (tx_valid_out && !tx_done_in && !tx_fail_in |=> tx_valid_out && $stable(tx_frame_out))
            else $error("offer changed");
    a_offer_drop:
        assert property (tx_valid_out && (tx_done_in || tx_fail_in) |=> !tx_valid_out) else $error("offer kept");
    a_irq_cause:
        assert property (irq_node_out != 8'h0 |-> $past(rx_valid_in || tx_done_in)) else $error("stray irq");
    a_rx_one_node:
        assert property ($past(rx_valid_in) && !$past(tx_done_in) |-> $onehot0(irq_node_out))
            else $error("several irq nodes");
endmodule // mo_ctrl_checker
bind mo_ctrl mo_ctrl_checker u_chk (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .rx_valid_in(rx_valid_in), .tx_done_in(tx_done_in),
    .tx_fail_in(tx_fail_in), .tx_valid_out(tx_valid_out), .tx_frame_out(tx_frame_out),
    .irq_node_out(irq_node_out));
`default_nettype wire

// file: tb/can_node_model.sv
// node controller and bus side model: sends frames and answers offers
`timescale 1ns/1ps
`default_nettype none
module can_node_model
    import mo_ctrl_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic tx_valid_in,
    input wire frame_t tx_frame_in,
    output logic rx_valid_out,
    output frame_t rx_frame_out,
    output logic tx_start_out,
    output logic tx_done_out,
    output logic tx_fail_out
);
    int gap = 1;
    int tx_count = 0;
    logic fail_next = 1'h0;
    frame_t last_tx;
    initial begin
        {rx_valid_out, tx_start_out, tx_done_out, tx_fail_out} = 4'h0;
        rx_frame_out = '0;
    end
    task automatic put_rx(input frame_t f);
        @(posedge clk_sys_in);
        rx_valid_out <= 1'h1;
        rx_frame_out <= f;
        @(posedge clk_sys_in);
        rx_valid_out <= 1'h0;
        rx_frame_out <= ~f;
    endtask
    // start then done or fail, pace set by gap
    always begin
        @(posedge clk_sys_in);
        if (tx_valid_in) begin
            last_tx = tx_frame_in;
            repeat (gap) @(posedge clk_sys_in);
            tx_start_out <= 1'h1;
            @(posedge clk_sys_in);
            tx_start_out <= 1'h0;
            repeat (gap) @(posedge clk_sys_in);
            tx_fail_out <= fail_next;
            tx_done_out <= !fail_next;
            @(posedge clk_sys_in);
            {tx_fail_out, tx_done_out} <= 2'h0;
            tx_count += int'(!fail_next);
            fail_next = 1'h0;
            repeat (2) @(posedge clk_sys_in);
        end
    end
endmodule // can_node_model
`default_nettype wire

// file: tb/test_can_message_object_control.sv
// register level test of the message object control block
`timescale 1ns/1ps
`default_nettype none
module test_can_message_object_control
    import mo_ctrl_pkg::*;
;
    logic clk_sys_in, rstn_in, wr_in, rd_in, rx_valid_in, tx_start_in, tx_done_in, tx_fail_in, tx_valid_out;
    logic [7:0] addr_in, irq_node_out, irq_seen;
    logic [31:0] wdata_in, rdata_out;
    frame_t rx_frame_in, tx_frame_out;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    mo_ctrl DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rx_valid_in(rx_valid_in),
        .rx_frame_in(rx_frame_in), .tx_start_in(tx_start_in), .tx_done_in(tx_done_in),
        .tx_fail_in(tx_fail_in), .tx_valid_out(tx_valid_out), .tx_frame_out(tx_frame_out),
        .irq_node_out(irq_node_out));
    can_node_model node (.clk_sys_in(clk_sys_in), .tx_valid_in(tx_valid_out), .tx_frame_in(tx_frame_out),
        .rx_valid_out(rx_valid_in), .rx_frame_out(rx_frame_in), .tx_start_out(tx_start_in),
        .tx_done_out(tx_done_in), .tx_fail_out(tx_fail_in));
    initial begin
        clk_sys_in = 1'h0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        irq_seen <= irq_seen | irq_node_out;
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        if (err_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] o, input logic [2:0] r, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr_in <= {1'h0, o, r, 2'h0};
        wdata_in <= d;
        wr_in <= 1'h1;
        @(posedge clk_sys_in);
        wr_in <= 1'h0;
    endtask
    task automatic rd(input logic [1:0] o, input logic [2:0] r, input logic [31:0] m, input logic [31:0] e,
        input string what);
        @(posedge clk_sys_in);
        addr_in <= {1'h0, o, r, 2'h0};
        rd_in <= 1'h1;
        @(posedge clk_sys_in);
        rd_in <= 1'h0;
        #1 chk(rdata_out & m, e & m, what);
    endtask
    function automatic logic [31:0] el(input int p, input logic [1:0] v);
        return (32'hffff & ~(32'h3 << p)) | ({30'h0, v} << p);
    endfunction
    task automatic rdp(input logic [1:0] o, input int p, input logic [1:0] v);
        rd(o, REG_CTRL, 32'h3 << p, {30'h0, v} << p, "control pair");
    endtask
    task automatic wait_tx(input int n, input logic [1:0] o);
        for (int i = 0; i < 300 && node.tx_count < n; i++) @(posedge clk_sys_in);
        chk(node.tx_count, n, "sent frames");
        chk(node.last_tx.obj, o, "sent object");
    endtask
    initial begin
        {rstn_in, wr_in, rd_in, addr_in, wdata_in, irq_seen} = '0;
        repeat (16) @(posedge clk_sys_in);
        rstn_in <= 1'h1;
        rd(2, REG_CTRL, '1, 32'h5555, "control reset");
        rd(0, 3'h5, '1, 32'h0, "unmapped");
        wr(0, REG_CFG, 32'h0005_0000);
        wr(0, REG_CTRL, el(P_VALID, EL_SET) & el(P_RECEIVE_IRQ_ENABLE, EL_SET));
        wr(0, REG_CFG, 32'h0005_0006);
        node.put_rx(frame_t'{2'h0, 1'h1, 1'h0, 1'h1, 29'h0abc, 4'hc, 64'h8877665544332211});
        rdp(0, P_NEW_DATA_FLAG, EL_CLR);
        wr(0, REG_CTRL, el(P_VALID, EL_SET));
        // clear away from the rising edge so the collecting process cannot restore old bits
        @(negedge clk_sys_in) irq_seen = 8'h0;
        node.put_rx(frame_t'{2'h0, 1'h1, 1'h0, 1'h1, 29'h0abc, 4'hc, 64'h8877665544332211});
        rdp(0, P_NEW_DATA_FLAG, EL_SET);
        chk(irq_seen, 8'h20, "rx irq node");
        rd(0, REG_CFG, 32'hf0, 32'hc0, "rx length");
        node.put_rx(frame_t'{2'h0, 1'h1, 1'h0, 1'h1, 29'h0abc, 4'h2, 64'h8877665544332211});
        rdp(0, P_LOST, EL_SET);
        wr(0, REG_CTRL, el(P_NEW_DATA_FLAG, EL_CLR));
        rd(0, REG_DLO, '1, 32'h44332211, "data low");
        rdp(0, P_NEW_DATA_FLAG, EL_CLR);
        node.put_rx(frame_t'{2'h0, 1'h1, 1'h1, 1'h1, 29'h0abc, 4'h0, 64'h0});
        rdp(0, P_TRANSMIT_REQUEST, EL_SET);
        rdp(0, P_REMOTE_PENDING, EL_SET);
        repeat (10) @(posedge clk_sys_in);
        chk(node.tx_count, 0, "inhibited");
        wr(0, REG_CTRL, el(P_LOST, EL_CLR));
        wait_tx(1, 2'h0);
        chk({node.last_tx.remote, node.last_tx.identifier_type, node.last_tx.node}, 3'h7, "remote frame");
        rd(0, REG_CTRL, 32'hf000, 32'h5000, "request cleared");
        for (int o = 1; o < 4; o++) wr(o[1:0], REG_CFG, 32'h0030_00c9);
        wr(2, REG_CTRL, el(P_VALID, EL_SET));
        wr(3, REG_CTRL, el(P_VALID, EL_SET));
        node.gap = 6;
        wr(1, REG_CTRL, el(P_VALID, EL_SET) & el(P_TRANSMIT_IRQ_ENABLE, EL_SET) & el(P_LOST, EL_SET) & el(P_TRANSMIT_REQUEST, EL_SET));
        repeat (10) @(posedge clk_sys_in);
        chk(node.tx_count, 1, "cpu update");
        @(negedge clk_sys_in) irq_seen = 8'h0;
        wr(1, REG_CTRL, el(P_LOST, EL_CLR) & el(P_NEW_DATA_FLAG, EL_SET));
        wr(3, REG_CTRL, el(P_TRANSMIT_REQUEST, EL_SET));
        wr(2, REG_CTRL, el(P_TRANSMIT_REQUEST, EL_SET));
        node.fail_next = 1'h1;
        wait_tx(2, 2'h1);
        chk({node.last_tx.remote, node.last_tx.dlc}, 5'h8, "data frame clipped");
        wait_tx(3, 2'h2);
        wait_tx(4, 2'h3);
        chk(irq_seen, 8'h08, "tx irq node");
        rd(1, REG_CTRL, 32'h3300, 32'h1100, "sent object flags");
        rd(1, REG_CFG, 32'hf0, 32'hc0, "stored length");
        node.put_rx(frame_t'{2'h1, 1'h0, 1'h1, 1'h0, 29'h155, 4'h3, 64'h0});
        rd(1, REG_ARB, '1, 32'h155, "monitored id");
        rd(1, REG_CFG, 32'hf0, 32'h30, "monitored length");
        wait_tx(5, 2'h1);
        chk(node.last_tx.id, 32'h155, "sent monitored id");
        chk(node.last_tx.dlc, 32'h3, "sent monitored length");
        end_of_test();
    end
endmodule // test_can_message_object_control
`default_nettype wire
